// ---- rtl/startup_consts.svh ----
// Constants of the start-up sequencer: timing, tables, register map
// Assumes a 100 MHz CLK; included by the package and the design modules
// Behaviour
// - Sample straps after memory check, then ready
// - Wait at least 2 ms after enable
// - Decode soft-start strap into delay, ramp, lockout
// - Soft-start strap read at start-up or reload
// - Delay and ramp programmable; zero delay gives 2 ms
// - Ok flag: output in window, no fault
// - Window limits and flag polarity programmable
// - Ok flag delayed, default equals ramp time
// - Mode strap selects sync pin role
// - Output role drives internal oscillator out
// - Input role checks clock, locks at enable
// - Clock loss falls back to last frequency
// - Auto role follows present clock like input
// - Auto role without clock uses pin strap
// - Frequency strap read only at start-up
// - Nineteen resistors select fixed switching frequencies
// - Programmed frequency is 8 MHz over N
// - Read-back frequency shows divider quantisation
// - Memory check ignores enable and bus
// - Delays below 2 ms become 2 ms
// - Delay counts from enable, then ramp starts
`ifndef STARTUP_CONSTS_SVH
`define STARTUP_CONSTS_SVH

// ==========================================================
// Timing
`define CLK_KHZ     100000
`define CLK_NS      10
`define ONE_MS      1
`define MEMCHK_MS   16'd5
`define PRERAMP_MS  16'd2
`define LOSS_NS     10000
`define LOSS_CYC    (`LOSS_NS / `CLK_NS)
`define OSC_STEP    5'd2
`define OSC_MOD     5'd25
`define FOSC_KHZ    16'd8000

// ==========================================================
// Soft-start table
`define T_SEL0        16'd2
`define T_SEL1        16'd5
`define T_SEL2        16'd10
`define T_SEL3        16'd20
`define SS_RES_MAX    6'd30
`define SS_FIRST_GRP  6'd3
`define SS_HI_LOCK    6'd15

// ==========================================================
// Divider and window
`define N_MIN       6'd6
`define N_MAX       6'd40
`define N_200K      6'd40
`define N_400K      6'd20
`define N_1M        6'd8
`define PCT_FULL    10'd100
`define WIN_LO_DEF  8'd10
`define WIN_HI_DEF  8'd15
`define OK_POL_DEF  1'b1
`define SYNC_W      20

// ==========================================================
// Register map and control bits
`define A_CTRL    8'h00
`define A_SSDLY   8'h04
`define A_SSRAMP  8'h08
`define A_OKDLY   8'h0C
`define A_WIN     8'h10
`define A_FREQ    8'h14
`define A_STATUS  8'h18
`define B_RELOAD  0
`define B_OKPOL   1

`endif

// ---- rtl/startup_pkg.sv ----
// Types shared by the start-up sequencer modules
// Assumes startup_consts.svh on the include path
`include "startup_consts.svh"
package startup_pkg;

  // ==========================================================
  // Strap levels and decoded settings
  typedef enum logic [1:0] {PIN_LOW, PIN_OPEN, PIN_HIGH, PIN_RES} strap_e;
  typedef struct packed {
    strap_e     level;
    logic [5:0] idx;
  } strap_s;
  typedef struct packed {
    logic [15:0] delay;
    logic [15:0] ramp;
    logic        lock_hi;
  } ss_cfg_s;

  // ==========================================================
  // Sequencer states and module state records
  typedef enum logic [2:0] {S_MEMCHK, S_LOAD, S_READY, S_DELAY, S_RAMP, S_ON} seq_e;
  typedef struct packed {
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
  } sync_state_s;
  typedef struct packed {
    logic        lvl_d;
    logic        seen;
    logic [10:0] cnt;
    logic [10:0] period;
  } mon_state_s;
  typedef struct packed {
    seq_e        st;
    logic        boot;
    logic        reload;
    logic [16:0] msdiv;
    logic [15:0] mscnt;
    ss_cfg_s     ss;
    logic [15:0] ok_dly;
    logic [15:0] ok_cnt;
    logic [7:0]  win_lo;
    logic [7:0]  win_hi;
    logic        ok_pol;
    strap_e      role;
    logic [5:0]  strap_n;
    logic [5:0]  prog_n;
    logic        prog_en;
    logic        ext_use;
    logic [5:0]  cur_n;
    logic [4:0]  osc_acc;
    logic [5:0]  div_cnt;
    logic        sw_clk;
    logic        oe;
    logic        okf;
    logic        ok_pin;
    logic        ramp_en;
    logic [31:0] prdata;
  } seq_state_s;

endpackage : startup_pkg

// ---- rtl/sync2.sv ----
// Two-stage synchroniser for all pin inputs
// Assumes inputs asynchronous to CLK
`timescale 1ns/1ns
`include "startup_consts.svh"
module sync2
  import startup_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [`SYNC_W-1:0] din,
  output logic      [`SYNC_W-1:0] dout
);
  sync_state_s s_ff;
  sync_state_s nxt_s;

  // Shift through two stages
  always_comb begin
    nxt_s    = s_ff;
    nxt_s.s1 = din;
    nxt_s.s2 = s_ff.s1;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign dout = s_ff.s2;
endmodule : sync2

// ---- rtl/clk_monitor.sv ----
// Presence and period monitor for the external sync clock
// Assumes a synchronised level on lvl
`timescale 1ns/1ns
`include "startup_consts.svh"
module clk_monitor
  import startup_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        lvl,
  output logic             present,
  output logic      [10:0] period
);
  mon_state_s s_ff;
  mon_state_s nxt_s;
  logic       rise;

  // Count cycles between rising edges, drop presence on timeout
  always_comb begin
    nxt_s       = s_ff;
    rise        = lvl & ~s_ff.lvl_d;
    nxt_s.lvl_d = lvl;
    if (rise) begin
      nxt_s.period = s_ff.cnt;
      nxt_s.cnt    = '0;
      nxt_s.seen   = 1'b1;
    end else if (s_ff.cnt < 11'(`LOSS_CYC)) begin
      nxt_s.cnt = s_ff.cnt + 11'd1;
    end else begin
      nxt_s.seen = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign present = s_ff.seen;
  assign period  = s_ff.period;
endmodule : clk_monitor

// ---- rtl/startup_seq.sv ----
// Start-up sequencer, soft-start timing, ok flag and clock select
// Assumes an APB master on CLK; straps arrive as decoded levels
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "startup_consts.svh"
module startup_seq
  import startup_pkg::*;
#(
  parameter int MS_CYCLES = `CLK_KHZ * `ONE_MS
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        EN_PIN,
  input  wire strap_s      SS_STRAP,
  input  wire strap_e      CFG_STRAP,
  input  wire strap_s      SYNC_STRAP,
  input  wire logic        SYNC_IN,
  output logic             SYNC_OUT,
  output logic             SYNC_OE,
  input  wire logic [15:0] VOUT_MV,
  input  wire logic [15:0] TARGET_MV,
  input  wire logic        FAULT,
  output logic             READY,
  output logic             RAMP_EN,
  output logic      [15:0] RAMP_MS,
  output logic             LOCKOUT_HI,
  output logic             SW_CLK,
  output logic             OUTPUT_OK_FLAG
);

  // ==========================================================
  // Lookup and arithmetic helpers

  // Table time from a two-bit selector
  function automatic logic [15:0] sel_ms(input logic [1:0] s);
    case (s)
      2'd0:    sel_ms = `T_SEL0;
      2'd1:    sel_ms = `T_SEL1;
      2'd2:    sel_ms = `T_SEL2;
      default: sel_ms = `T_SEL3;
    endcase
  endfunction : sel_ms

  // Soft-start strap to delay, ramp and lockout
  function automatic ss_cfg_s ss_decode(input strap_s p);
    logic [5:0] i;
    ss_cfg_s    c;
    i         = (p.idx > `SS_RES_MAX) ? `SS_RES_MAX : p.idx;
    c.lock_hi = 1'b0;
    case (p.level)
      PIN_LOW, PIN_OPEN, PIN_HIGH: begin
        c.delay = sel_ms(2'(p.level));
        c.ramp  = c.delay;
      end
      default: begin
        // Four rows per delay group, first group short
        c.delay   = sel_ms(2'((i + 6'd1) >> 2));
        c.ramp    = (i < `SS_FIRST_GRP) ? sel_ms(i[1:0]) : sel_ms(2'(i + 6'd1));
        c.lock_hi = (i >= `SS_HI_LOCK);
      end
    endcase
    ss_decode = c;
  endfunction : ss_decode

  // Frequency strap to divider N
  function automatic logic [5:0] freq_n_of(input strap_s p);
    case (p.level)
      PIN_LOW:  freq_n_of = `N_200K;
      PIN_OPEN: freq_n_of = `N_400K;
      PIN_HIGH: freq_n_of = `N_1M;
      default: begin
        case (p.idx)
          6'd0:    freq_n_of = 6'd40;
          6'd1:    freq_n_of = 6'd36;
          6'd2:    freq_n_of = 6'd33;
          6'd3:    freq_n_of = 6'd30;
          6'd4:    freq_n_of = 6'd27;
          6'd5:    freq_n_of = 6'd25;
          6'd6:    freq_n_of = 6'd22;
          6'd7:    freq_n_of = 6'd20;
          6'd8:    freq_n_of = 6'd19;
          6'd9:    freq_n_of = 6'd17;
          6'd10:   freq_n_of = 6'd15;
          6'd11:   freq_n_of = 6'd14;
          6'd12:   freq_n_of = 6'd13;
          6'd13:   freq_n_of = 6'd11;
          6'd14:   freq_n_of = 6'd10;
          6'd16:   freq_n_of = 6'd9;
          6'd17:   freq_n_of = 6'd8;
          6'd18:   freq_n_of = 6'd7;
          6'd20:   freq_n_of = 6'd6;
          default: freq_n_of = `N_400K;   // Unlisted resistor
        endcase
      end
    endcase
  endfunction : freq_n_of

  // Limit a divider value to the legal range
  function automatic logic [5:0] n_clamp(input logic [15:0] v);
    n_clamp = (v < 16'(`N_MIN)) ? `N_MIN
            : (v > 16'(`N_MAX)) ? `N_MAX : v[5:0];
  endfunction : n_clamp

  // ==========================================================
  // Pin synchronisation and clock monitor
  logic [`SYNC_W-1:0] pins;
  logic               en_s;
  logic               ext_lvl;
  strap_s             ss_s;
  strap_e             cfg_s;
  strap_s             fs_s;
  logic               ext_ok;
  logic [10:0]        ext_per;

  sync2 u_sync (
    .clk  (CLK),
    .rst  (RST),
    .din  ({EN_PIN, SYNC_IN, SS_STRAP, CFG_STRAP, SYNC_STRAP}),
    .dout (pins)
  );
  assign {en_s, ext_lvl, ss_s, cfg_s, fs_s} = pins;

  clk_monitor u_mon (
    .clk     (CLK),
    .rst     (RST),
    .lvl     (ext_lvl),
    .present (ext_ok),
    .period  (ext_per)
  );

  // ==========================================================
  // Sequencer state
  seq_state_s s_ff;
  seq_state_s nxt_s;
  logic       tick;
  logic       tick8;
  logic       busy;
  logic       acc;
  logic       wr;
  logic       mapped;
  logic [31:0] rdata;
  logic [15:0] dly_eff;
  logic [5:0]  meas_n;
  logic [25:0] v_sc;
  logic [25:0] lo_lim;
  logic [25:0] hi_lim;
  logic        ok_cond;

  // Bus phase decode and register read mux
  always_comb begin
    busy   = (s_ff.st == S_MEMCHK);
    acc    = PSEL & PENABLE;
    mapped = 1'b1;
    case (PADDR)
      `A_CTRL:   rdata = 32'({s_ff.prog_en, s_ff.ok_pol});
      `A_SSDLY:  rdata = 32'(s_ff.ss.delay);
      `A_SSRAMP: rdata = 32'(s_ff.ss.ramp);
      `A_OKDLY:  rdata = 32'(s_ff.ok_dly);
      `A_WIN:    rdata = 32'({s_ff.win_hi, s_ff.win_lo});
      `A_FREQ:   rdata = 32'(`FOSC_KHZ / 16'(s_ff.cur_n));
      `A_STATUS: rdata = 32'({s_ff.cur_n, s_ff.ext_use, ext_ok,
                              s_ff.ss.lock_hi, s_ff.okf, s_ff.st});
      default: begin
        rdata  = '0;
        mapped = 1'b0;
      end
    endcase
    wr = acc & PWRITE & mapped & ~busy;
  end

  // Timing helpers and window compare
  always_comb begin
    tick    = (s_ff.msdiv == 17'(MS_CYCLES - 1));
    tick8   = ((s_ff.osc_acc + `OSC_STEP) >= `OSC_MOD);
    dly_eff = (s_ff.ss.delay < `PRERAMP_MS) ? `PRERAMP_MS : s_ff.ss.delay;
    meas_n  = n_clamp(16'(({5'd0, ext_per} * `OSC_STEP + `OSC_MOD / 5'd2)
                          / `OSC_MOD));
    v_sc    = 26'(VOUT_MV) * 26'(`PCT_FULL);
    lo_lim  = (10'(s_ff.win_lo) >= `PCT_FULL) ? '0 :
              26'(TARGET_MV) * 26'(`PCT_FULL - 10'(s_ff.win_lo));
    hi_lim  = 26'(TARGET_MV) * 26'(`PCT_FULL + 10'(s_ff.win_hi));
    ok_cond = (s_ff.st == S_ON) & ~FAULT
            & (v_sc >= lo_lim) & (v_sc <= hi_lim);
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    nxt_s = s_ff;

    // Millisecond divider
    nxt_s.msdiv = tick ? '0 : s_ff.msdiv + 17'd1;

    // Register writes
    if (wr) begin
      case (PADDR)
        `A_CTRL: begin
          nxt_s.ok_pol = PWDATA[`B_OKPOL];
          if (PWDATA[`B_RELOAD]) begin
            nxt_s.reload = 1'b1;
          end
        end
        `A_SSDLY:  nxt_s.ss.delay = PWDATA[15:0];
        `A_SSRAMP: nxt_s.ss.ramp  = PWDATA[15:0];
        `A_OKDLY:  nxt_s.ok_dly   = PWDATA[15:0];
        `A_WIN: begin
          nxt_s.win_lo = PWDATA[7:0];
          nxt_s.win_hi = PWDATA[15:8];
        end
        `A_FREQ: begin
          nxt_s.prog_en = (PWDATA[15:0] != 16'd0);
          nxt_s.prog_n  = (PWDATA[15:0] == 16'd0) ? `N_MAX :
                          n_clamp(((16'(`FOSC_KHZ << 1) / PWDATA[15:0])
                                   + 16'd1) >> 1);
        end
        default: ;
      endcase
    end

    // Sequencer
    case (s_ff.st)
      S_MEMCHK: begin
        if (tick) begin
          nxt_s.mscnt = s_ff.mscnt + 16'd1;
          if (s_ff.mscnt + 16'd1 >= `MEMCHK_MS) begin
            nxt_s.st    = S_LOAD;
            nxt_s.mscnt = '0;
          end
        end
      end
      S_LOAD: begin
        nxt_s.ss     = ss_decode(ss_s);
        nxt_s.ok_dly = ss_decode(ss_s).ramp;
        if (!s_ff.boot) begin
          nxt_s.role    = cfg_s;
          nxt_s.strap_n = freq_n_of(fs_s);
          nxt_s.boot    = 1'b1;
        end
        nxt_s.st = S_READY;
      end
      S_READY: begin
        if (s_ff.reload && !wr) begin
          nxt_s.reload = 1'b0;
          nxt_s.st     = S_LOAD;
        end else if (en_s) begin
          nxt_s.st      = S_DELAY;
          nxt_s.mscnt   = '0;
          nxt_s.msdiv   = '0;
          nxt_s.ext_use = (s_ff.role == PIN_LOW || s_ff.role == PIN_OPEN)
                        & ext_ok;
          if (s_ff.role == PIN_HIGH) begin
            nxt_s.cur_n = `N_400K;
          end else if (s_ff.prog_en) begin
            nxt_s.cur_n = s_ff.prog_n;
          end else if (s_ff.role == PIN_OPEN) begin
            nxt_s.cur_n = s_ff.strap_n;
          end else begin
            nxt_s.cur_n = `N_400K;
          end
        end
      end
      S_DELAY: begin
        if (tick) begin
          nxt_s.mscnt = s_ff.mscnt + 16'd1;
          if (s_ff.mscnt + 16'd1 >= dly_eff) begin
            nxt_s.st      = S_RAMP;
            nxt_s.mscnt   = '0;
            nxt_s.ramp_en = 1'b1;
          end
        end
      end
      S_RAMP: begin
        if (tick) begin
          nxt_s.mscnt = s_ff.mscnt + 16'd1;
          if (s_ff.mscnt + 16'd1 >= s_ff.ss.ramp) begin
            nxt_s.st    = S_ON;
            nxt_s.mscnt = '0;
          end
        end
      end
      S_ON: ;
      default: nxt_s.st = S_MEMCHK;
    endcase

    // Enable withdrawn after start
    if (!en_s && (s_ff.st == S_DELAY || s_ff.st == S_RAMP || s_ff.st == S_ON)) begin
      nxt_s.st      = S_READY;
      nxt_s.ramp_en = 1'b0;
      nxt_s.ext_use = 1'b0;
      nxt_s.mscnt   = '0;
    end

    // Fall back to internal oscillator on clock loss
    if (s_ff.ext_use && !ext_ok) begin
      nxt_s.ext_use = 1'b0;
      nxt_s.cur_n   = meas_n;
    end

    // Ok flag with delay on rise, none on fall
    if (!ok_cond) begin
      nxt_s.okf    = 1'b0;
      nxt_s.ok_cnt = '0;
    end else if (!s_ff.okf) begin
      if (s_ff.ok_cnt >= s_ff.ok_dly) begin
        nxt_s.okf = 1'b1;
      end else if (tick) begin
        nxt_s.ok_cnt = s_ff.ok_cnt + 16'd1;
      end
    end
    nxt_s.ok_pin = nxt_s.okf ~^ nxt_s.ok_pol;

    // Switching clock: external level or internal divider
    nxt_s.osc_acc = tick8 ? s_ff.osc_acc + `OSC_STEP - `OSC_MOD
                          : s_ff.osc_acc + `OSC_STEP;
    if (s_ff.ext_use) begin
      nxt_s.sw_clk = ext_lvl;
    end else if (tick8) begin
      nxt_s.div_cnt = (s_ff.div_cnt >= s_ff.cur_n - 6'd1) ? '0
                    : s_ff.div_cnt + 6'd1;
      nxt_s.sw_clk  = (nxt_s.div_cnt < (s_ff.cur_n >> 1));
    end
    nxt_s.oe = nxt_s.boot & (nxt_s.role == PIN_HIGH);

    // Read data captured in setup phase
    if (PSEL && !PENABLE) begin
      nxt_s.prdata = busy ? '0 : rdata;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      s_ff         <= '0;
      s_ff.st      <= S_MEMCHK;
      s_ff.win_lo  <= `WIN_LO_DEF;
      s_ff.win_hi  <= `WIN_HI_DEF;
      s_ff.ok_pol  <= `OK_POL_DEF;
      s_ff.ok_pin  <= ~`OK_POL_DEF;
      s_ff.role    <= PIN_OPEN;
      s_ff.strap_n <= `N_400K;
      s_ff.prog_n  <= `N_400K;
      s_ff.cur_n   <= `N_400K;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Outputs
  assign PRDATA         = s_ff.prdata;
  assign PREADY         = 1'b1;
  assign PSLVERR        = acc & (~mapped | busy);
  assign READY          = (s_ff.st == S_READY);
  assign RAMP_EN        = s_ff.ramp_en;
  assign RAMP_MS        = s_ff.ss.ramp;
  assign LOCKOUT_HI     = s_ff.ss.lock_hi;
  assign SW_CLK         = s_ff.sw_clk;
  assign SYNC_OUT       = s_ff.sw_clk;
  assign SYNC_OE        = s_ff.oe;
  assign OUTPUT_OK_FLAG = s_ff.ok_pin;

endmodule : startup_seq

// ---- tb/startup_seq_assertions.sv ----
// Port checker for the start-up sequencer
// Assumes binding onto startup_seq with its MS_CYCLES value
`timescale 1ns/1ns
`include "startup_consts.svh"
module startup_seq_checker
  import startup_pkg::*;
#(
  parameter int MS_CYCLES = 100
) (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic       PREADY,
  input wire logic       PSLVERR,
  input wire logic       EN_PIN,
  input wire strap_e     CFG_STRAP,
  input wire logic       SYNC_OE,
  input wire logic       FAULT,
  input wire logic       READY,
  input wire logic       RAMP_EN,
  input wire logic       OUTPUT_OK_FLAG
);
  // ============================================================
  // Helper state
  logic [15:0] up_cnt;
  logic [15:0] en_cnt;
  logic        seen_rdy;
  logic        pol_ff;

  // Uptime, enable length, ready seen, tracked flag polarity
  always_ff @(posedge CLK) begin
    if (RST) begin
      up_cnt   <= 16'h0;
      en_cnt   <= 16'h0;
      seen_rdy <= 1'h0;
      pol_ff   <= 1'h1;
    end else begin
      up_cnt   <= (up_cnt == 16'hFFFF) ? up_cnt : up_cnt + 16'h1;
      en_cnt   <= !EN_PIN ? 16'h0 : (en_cnt == 16'hFFFF) ? en_cnt : en_cnt + 16'h1;
      seen_rdy <= seen_rdy | READY;
      if (seen_rdy && PSEL && PENABLE && PWRITE && PADDR == `A_CTRL) begin
        pol_ff <= PWDATA[`B_OKPOL];
      end
    end
  end

  // ============================================================
  // Assertions
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  a_check_first: assert property (READY |-> up_cnt >= 5 * MS_CYCLES)
    else $error("ready before memory check end");
  a_bus_early: assert property (PSEL && PENABLE && up_cnt < 5 * MS_CYCLES |-> PSLVERR)
    else $error("bus access taken during memory check");
  a_unmapped_err: assert property (PSEL && PENABLE && PADDR > `A_STATUS |-> PSLVERR)
    else $error("unmapped access without error");
  a_ramp_delay: assert property ($rose(RAMP_EN) |-> en_cnt >= 2 * MS_CYCLES)
    else $error("ramp before pre-ramp delay");
  a_ramp_stops: assert property ($fell(EN_PIN) |-> ##[1:4] !RAMP_EN)
    else $error("ramp kept after enable low");
  a_ramp_busy: assert property (RAMP_EN |-> !READY)
    else $error("ready while ramping");
  a_role_drive: assert property (READY |-> SYNC_OE == (CFG_STRAP == PIN_HIGH))
    else $error("sync pin drive mismatch");
  a_fault_clears: assert property (FAULT && pol_ff |-> ##[1:2] !OUTPUT_OK_FLAG)
    else $error("ok flag kept under fault");
  a_ok_needs_on: assert property (pol_ff && $rose(OUTPUT_OK_FLAG) |-> RAMP_EN)
    else $error("ok flag without ramp");
endmodule : startup_seq_checker

bind startup_seq startup_seq_checker #(.MS_CYCLES(MS_CYCLES)) chk_i (.*);

// ---- tb/sync_src.sv ----
// External sync clock source on the shared sync pin
// Assumes the bench merges its level with the design's drive
`timescale 1ns/1ns
module sync_src #(
  parameter int HALF_NS = 1000
) (
  input  wire logic run,
  output logic      lvl
);
  // ============================================================
  // Free 500 kHz clock while run, held low when stopped
  initial lvl = 1'h0;
  always begin
    #HALF_NS;
    lvl = run ? ~lvl : 1'h0;
  end
endmodule : sync_src

// ---- tb/tb.sv ----
// Self-checking bench for the start-up sequencer
// Assumes MS_CYCLES of 100 and the sync source model
`timescale 1ns/1ns
`include "startup_consts.svh"
module tb;
  import startup_pkg::*;
  logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic        EN_PIN, SYNC_IN, SYNC_OUT, SYNC_OE, FAULT, READY, RAMP_EN;
  logic        LOCKOUT_HI, SW_CLK, OUTPUT_OK_FLAG, e, run, src_lvl;
  strap_s      SS_STRAP, SYNC_STRAP;
  strap_e      CFG_STRAP;
  logic [15:0] VOUT_MV, TARGET_MV, RAMP_MS;
  logic [32:0] ex;
  logic [32:0] pv;
  int          n, p, miscompares, checks_done;
  strap_s      cs [5] = '{'{PIN_LOW, 6'h0}, '{PIN_OPEN, 6'h0}, '{PIN_HIGH, 6'h0},
                          '{PIN_RES, 6'h1}, '{PIN_RES, 6'h1B}};
  logic [15:0] vv [6] = '{16'h383, 16'h384, 16'h47E, 16'h47F, 16'h3B5, 16'h4B0};
  logic        ee [6] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1};

  startup_seq #(.MS_CYCLES(100)) uut (.*);
  sync_src src (.run(run), .lvl(src_lvl));
  assign SYNC_IN = SYNC_OE ? SYNC_OUT : src_lvl;

  // ============================================================
  // Clock
  initial begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end

  // ============================================================
  // Helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    checks_done++;
    if (g !== w) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, w);
    end
  endtask : chk
  task automatic rng(input int c, input int lo, input int hi);
    checks_done++;
    if (c < lo || c > hi) begin
      miscompares++;
      $display("unexpected at %0t: count %0d", $time, c);
    end
  endtask : rng
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    do @(posedge CLK); while (PREADY !== 1'h1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask : xfer
  function automatic logic sig(input int k);
    case (k)
      0: return READY;
      1: return RAMP_EN;
      2: return OUTPUT_OK_FLAG;
      3: return SYNC_OUT;
      default: return SW_CLK;
    endcase
  endfunction : sig
  task automatic till(input int k, input logic v);
    n = 0;
    while (sig(k) !== v && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    if (sig(k) !== v) begin
      miscompares++;
      $display("unexpected at %0t: wait timed out", $time);
    end
  endtask : till
  task automatic per(input int k, input int lo, input int hi);
    till(k, 1'h0);
    till(k, 1'h1);
    till(k, 1'h0);
    p = n;
    till(k, 1'h1);
    rng(p + n, lo, hi);
  endtask : per
  function automatic logic [32:0] ss_exp(input strap_s s);
    logic [15:0] t [4];
    int i;
    t = '{16'h2, 16'h5, 16'hA, 16'h14};
    i = int'(s.idx) - 3;
    if (s.level != PIN_RES) return {t[s.level], t[s.level], 1'h0};
    if (i < 0) return {t[0], t[i + 3], 1'h0};
    return {t[(i / 4 + 1) % 4], t[i % 4], s.idx >= 6'hF};
  endfunction : ss_exp
  task automatic boot(input strap_e c, input logic r);
    RST <= 1'h1;
    CFG_STRAP <= c;
    run <= r;
    EN_PIN <= 1'h0;
    repeat (6) @(posedge CLK);
    RST <= 1'h0;
    xfer(1'h0, `A_STATUS, 32'h0);
    chk(e, 1'h1);
    till(0, 1'h1);
  endtask : boot
  task automatic go(input int lo);
    EN_PIN <= 1'h1;
    till(1, 1'h1);
    rng(n, lo, lo + 6);
  endtask : go
  task automatic stat;
    EN_PIN <= 1'h0;
    repeat (5) @(posedge CLK);
    EN_PIN <= 1'h1;
    repeat (20) @(posedge CLK);
    xfer(1'h0, `A_STATUS, 32'h0);
  endtask : stat
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // ============================================================
  // Watchdog
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  // ============================================================
  // Main sequence
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, FAULT} = '0;
    SS_STRAP = cs[0];
    SYNC_STRAP = '{PIN_RES, 6'h6};
    VOUT_MV = 16'h3E8;
    TARGET_MV = 16'h3E8;
    pv = ss_exp(cs[0]);
    boot(PIN_HIGH, 1'h0);
    // Strap table, reload and no change before reload
    foreach (cs[i]) begin
      SS_STRAP <= cs[i];
      ex = ss_exp(cs[i]);
      repeat (4) @(posedge CLK);
      xfer(1'h0, `A_SSDLY, 32'h0);
      chk(q, pv[32:17]);
      xfer(1'h1, `A_CTRL, 32'h3);
      repeat (3) @(posedge CLK);
      xfer(1'h0, `A_SSDLY, 32'h0);
      chk(q, ex[32:17]);
      xfer(1'h0, `A_OKDLY, 32'h0);
      chk(q, ex[16:1]);
      chk({RAMP_MS, LOCKOUT_HI}, ex[16:0]);
      pv = ex;
    end
    xfer(1'h0, 8'h1C, 32'h0);
    chk({q, e}, 33'h1);
    chk(SYNC_OE, 1'h1);
    xfer(1'h1, `A_SSDLY, 32'h0);
    xfer(1'h1, `A_SSRAMP, 32'h1);
    xfer(1'h1, `A_OKDLY, 32'h0);
    go(200);
    per(3, 249, 251);
    till(2, 1'h1);
    FAULT <= 1'h1;
    repeat (3) @(posedge CLK);
    chk(OUTPUT_OK_FLAG, 1'h0);
    FAULT <= 1'h0;
    // Window edges, then a shifted window
    foreach (vv[k]) begin
      if (k == 4) xfer(1'h1, `A_WIN, 32'h1405);
      VOUT_MV <= vv[k];
      repeat (4) @(posedge CLK);
      chk(OUTPUT_OK_FLAG, ee[k]);
    end
    xfer(1'h1, `A_CTRL, 32'h0);
    repeat (3) @(posedge CLK);
    chk(OUTPUT_OK_FLAG, 1'h0);
    xfer(1'h1, `A_CTRL, 32'h2);
    xfer(1'h1, `A_OKDLY, 32'h2);
    VOUT_MV <= 16'h383;
    repeat (4) @(posedge CLK);
    VOUT_MV <= 16'h3E8;
    till(2, 1'h1);
    rng(n, 100, 205);
    EN_PIN <= 1'h0;
    repeat (5) @(posedge CLK);
    chk({RAMP_EN, READY}, 2'h1);
    xfer(1'h1, `A_SSDLY, 32'h3);
    go(300);
    // Input role: follow, then lose the clock
    boot(PIN_LOW, 1'h1);
    stat();
    chk(q[6:5], 2'h3);
    per(4, 199, 201);
    run <= 1'h0;
    repeat (1200) @(posedge CLK);
    xfer(1'h0, `A_STATUS, 32'h0);
    chk({q[12:7], q[6]}, 7'h20);
    xfer(1'h0, `A_FREQ, 32'h0);
    chk(q, 32'h1F4);
    // Auto role: strap, late strap change, program, clock present
    boot(PIN_OPEN, 1'h0);
    stat();
    chk({q[12:7], q[6]}, 7'h2C);
    xfer(1'h0, `A_FREQ, 32'h0);
    chk(q, 32'h16B);
    SYNC_STRAP <= '{PIN_HIGH, 6'h0};
    stat();
    chk(q[12:7], 6'h16);
    xfer(1'h1, `A_FREQ, 32'h32A);
    stat();
    chk(q[12:7], 6'hA);
    xfer(1'h0, `A_FREQ, 32'h0);
    chk(q, 32'h320);
    run <= 1'h1;
    repeat (600) @(posedge CLK);
    stat();
    chk(q[6], 1'h1);
    complete_run();
  end
endmodule : tb
